// ---- hw/dbg_port_dev.sv ----
// Device end of the debug link with its transmit FIFO
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------------
// Transmit FIFO (depth must be a power of two)
// ----------------------------------------------------------------------------
module byte_fifo #(
    parameter int W = 8,
    parameter int D = 8
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_b,
    // Fill side
    input  wire logic [W-1:0] in_data,
    input  wire logic         in_valid,
    output logic              in_ready,
    // Drain side
    output logic [W-1:0]      out_data,
    output logic              out_valid,
    input  wire logic         out_ready
);
    localparam int AW = $clog2(D);
    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW:0]         wp;
        logic [AW:0]         rp;
    } fifo_s;
    fifo_s q;
    fifo_s d;

    // Full when pointers differ only in the wrap bit
    assign in_ready  = !((q.wp[AW] != q.rp[AW]) &&
                         (q.wp[AW-1:0] == q.rp[AW-1:0]));
    assign out_valid = (q.wp != q.rp);
    assign out_data  = q.mem[q.rp[AW-1:0]];

    // Pointer and storage update
    always_comb
    begin
        d = q;
        if (in_valid && in_ready)
        begin
            d.mem[q.wp[AW-1:0]] = in_data;
            d.wp = q.wp + {{AW{1'b0}}, 1'b1};
        end
        if (out_valid && out_ready)
            d.rp = q.rp + {{AW{1'b0}}, 1'b1};
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            q <= '0;
        else
            q <= d;
    end
endmodule

// ----------------------------------------------------------------------------
// Device end: debug mode control, auto-baud and serial engine
// ----------------------------------------------------------------------------
module dbg_port_dev #(
    parameter int          FIFO_DEPTH = dbg_link_pkg::FIFO_DEPTH,
    parameter bit          SMALL_PKG  = 1'b0,
    parameter logic [31:0] KEY        = dbg_link_pkg::UNLOCK_KEY
) (
    // Clock and power-on reset
    input  wire logic       clk,
    input  wire logic       rst_b,
    // Link pins
    dbg_link_if.dev         link,
    // Other reset sources
    input  wire logic       brownout_rst,
    input  wire logic       wdt_rst,
    // Core status and control
    input  wire logic       brk_exec,
    input  wire logic       stop_mode,
    input  wire logic       core_halted,
    input  wire logic       wdt_enabled,
    input  wire logic       exec_req,
    input  wire logic       debug_mode_clr,
    output logic            debug_active_bit,
    output logic            fetch_en,
    output logic            halt_exit,
    output logic            wdt_refresh,
    output logic            periph_run,
    output logic            sys_reset_req,
    output logic            unlocked,
    // Debugger bytes
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_valid,
    output logic            tx_ready,
    output logic [7:0]      rx_data,
    output logic            rx_valid
);
    typedef struct packed {
        logic                     p1;
        logic                     p2;
        logic                     pd;
        logic                     r1;
        logic                     r2;
        logic                     in_rst;
        dbg_link_pkg::dev_state_e st;
        logic                     dbg;
        logic                     unl;
        logic                     key_on;
        logic [15:0]              key_tmr;
        logic [5:0]               key_idx;
        logic [31:0]              key_sr;
        logic [15:0]              ab_cnt;
        logic [15:0]              bit_cyc;
        logic                     rx_on;
        logic [15:0]              rx_tmr;
        logic [3:0]               rx_idx;
        logic [7:0]               rx_sr;
        logic [7:0]               rx_data;
        logic                     rx_valid;
        logic                     tx_on;
        logic [15:0]              tx_tmr;
        logic [3:0]               tx_idx;
        logic [9:0]               tx_sr;
        logic                     fetch;
        logic                     hexit;
        logic                     wref;
        logic                     prun;
        logic                     rreq;
    } dev_s;
    dev_s q;
    dev_s d;

    logic       sys_rst;
    logic       ab_done;
    logic       strap;
    logic       enter;
    logic       pop;
    logic       f_valid;
    logic [7:0] f_data;

    byte_fifo #(.W(dbg_link_pkg::BYTE_W), .D(FIFO_DEPTH)) u_fifo (
        .clk       (clk),
        .rst_b     (rst_b),
        .in_data   (tx_data),
        .in_valid  (tx_valid),
        .in_ready  (tx_ready),
        .out_data  (f_data),
        .out_valid (f_valid),
        .out_ready (pop)
    );

    // Transmit only when the link is measured and the line is ours
    assign pop = (q.st == dbg_link_pkg::LINK_RUN) && !q.tx_on && !q.rx_on
                 && !sys_rst && f_valid;

    // Next-state logic
    always_comb
    begin
        d = q;
        d.p1 = link.pin;
        d.p2 = q.p1;
        d.pd = q.p2;
        d.r1 = link.rst_pin;
        d.r2 = q.r1;
        d.rx_valid = 1'b0;
        ab_done = 1'b0;
        d.rreq = stop_mode && !q.p2;
        sys_rst = !q.r2 || brownout_rst || wdt_rst || d.rreq;
        d.in_rst = sys_rst;

        // Key shifts in MSB first, timed from a leading zero bit
        if (!q.r2 && !q.unl)
        begin
            if (!q.key_on)
            begin
                if (q.pd && !q.p2)
                begin
                    d.key_on = 1'b1;
                    d.key_tmr = dbg_link_pkg::KEY_FIRST_M1;
                    d.key_idx = '0;
                end
            end
            else if (q.key_tmr == '0)
            begin
                d.key_sr = {q.key_sr[30:0], q.p2};
                d.key_idx = q.key_idx + 6'h01;
                d.key_tmr = dbg_link_pkg::KEY_BIT_M1;
                if (q.key_idx == dbg_link_pkg::KEY_LAST)
                begin
                    d.key_on = 1'b0;
                    d.unl = ({q.key_sr[30:0], q.p2} == KEY);
                end
            end
            else
                d.key_tmr = q.key_tmr - dbg_link_pkg::CNT_ONE;
        end
        else
            d.key_on = 1'b0;

        // Auto-baud: wait for idle high, then time the low run
        case (q.st)
            dbg_link_pkg::AB_WAIT_HIGH:
                if (q.p2)
                    d.st = dbg_link_pkg::AB_WAIT_LOW;
            dbg_link_pkg::AB_WAIT_LOW:
                if (!q.p2 && (!SMALL_PKG || q.unl))
                begin
                    d.st = dbg_link_pkg::AB_MEASURE;
                    d.ab_cnt = dbg_link_pkg::CNT_ONE;
                end
            dbg_link_pkg::AB_MEASURE:
                if (q.p2)
                begin
                    d.bit_cyc = q.ab_cnt >> dbg_link_pkg::AB_SHIFT;
                    if (d.bit_cyc >= dbg_link_pkg::MIN_BIT_CYC)
                    begin
                        d.st = dbg_link_pkg::LINK_RUN;
                        ab_done = 1'b1;
                    end
                    else
                        d.st = dbg_link_pkg::AB_WAIT_LOW;
                end
                else if (q.ab_cnt != dbg_link_pkg::CNT_MAX)
                    d.ab_cnt = q.ab_cnt + dbg_link_pkg::CNT_ONE;
            dbg_link_pkg::LINK_RUN:
            begin
                // Receive: mid-bit sampling at the measured rate
                if (q.rx_on)
                begin
                    if (q.rx_tmr == '0)
                    begin
                        d.rx_tmr = q.bit_cyc - dbg_link_pkg::CNT_ONE;
                        d.rx_idx = q.rx_idx + 4'h1;
                        if (q.rx_idx == '0)
                            d.rx_on = !q.p2;
                        else if (q.rx_idx == dbg_link_pkg::IDX_STOP)
                        begin
                            d.rx_on = 1'b0; // Reply may follow at once
                            d.rx_valid = q.p2;
                            if (q.p2)
                                d.rx_data = q.rx_sr;
                        end
                        else
                            d.rx_sr = {q.p2, q.rx_sr[7:1]};
                    end
                    else
                        d.rx_tmr = q.rx_tmr - dbg_link_pkg::CNT_ONE;
                end
                else if (!q.tx_on && q.pd && !q.p2)
                begin
                    d.rx_on = 1'b1;
                    d.rx_idx = '0;
                    d.rx_tmr = q.bit_cyc >> 1;
                end
                // Transmit: start, data LSB first, one full stop bit
                if (q.tx_on)
                begin
                    if (q.tx_tmr == '0)
                    begin
                        d.tx_sr = {1'b1, q.tx_sr[9:1]};
                        d.tx_idx = q.tx_idx + 4'h1;
                        d.tx_tmr = q.bit_cyc - dbg_link_pkg::CNT_ONE;
                        if (q.tx_idx == dbg_link_pkg::IDX_STOP)
                            d.tx_on = 1'b0;
                    end
                    else
                        d.tx_tmr = q.tx_tmr - dbg_link_pkg::CNT_ONE;
                end
                else if (pop)
                begin
                    d.tx_on = 1'b1;
                    d.tx_idx = '0;
                    d.tx_sr = {1'b1, f_data, 1'b0};
                    d.tx_tmr = q.bit_cyc - dbg_link_pkg::CNT_ONE;
                end
            end
            default:
                d.st = dbg_link_pkg::AB_WAIT_HIGH;
        endcase

        // Debug mode: entry beats a same-cycle clear
        strap = q.in_rst && !sys_rst && !SMALL_PKG && !q.p2;
        enter = brk_exec || strap || ab_done;
        d.dbg = enter || (q.dbg && !debug_mode_clr);
        d.hexit = enter && !q.dbg && core_halted;

        // Any system reset ends debug mode and restarts auto-baud
        if (sys_rst)
        begin
            d.dbg = 1'b0;
            d.hexit = 1'b0;
            d.st = dbg_link_pkg::AB_WAIT_HIGH;
            d.rx_on = 1'b0;
            d.tx_on = 1'b0;
            d.tx_sr = '1;
        end
        d.fetch = !d.dbg || exec_req;
        d.wref = d.dbg && wdt_enabled;
        d.prun = !stop_mode; // Debug mode does not gate this
    end

    // State register
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            q <= '0;
            q.p1 <= 1'b1;
            q.p2 <= 1'b1;
            q.pd <= 1'b1;
            q.tx_sr <= '1;
            q.fetch <= 1'b1;
            q.prun <= 1'b1;
            q.in_rst <= 1'b1;
        end
        else
            q <= d;
    end

    // Outputs straight from state
    assign link.dev_out     = q.tx_sr[0];
    assign link.dev_oe_b    = !q.tx_on;
    assign debug_active_bit = q.dbg;
    assign fetch_en         = q.fetch;
    assign halt_exit        = q.hexit;
    assign wdt_refresh      = q.wref;
    assign periph_run       = q.prun;
    assign sys_reset_req    = q.rreq;
    assign unlocked         = q.unl;
    assign rx_data          = q.rx_data;
    assign rx_valid         = q.rx_valid;
endmodule
`default_nettype wire

// ---- inc/dbg_link_pkg.sv ----
// Shared constants and types for the single-pin debug link
// ----------------------------------------------------------------------------
// Functional notes
// - Debug mode stops fetch except directed instructions
// - Clock and peripherals run in debug, not stop
// - Entering debug mode leaves halt automatically
// - Debug mode keeps refreshing an enabled watchdog
// - Breakpoint instruction enters debug mode
// - Large parts: pin low at reset end enters debug
// - Host keeps pin low 5000 cycles after reset
// - Small parts: key under reset unlocks debug
// - Writing debug bit to zero leaves debug
// - Any system reset leaves debug mode
// - Pin low in stop mode starts reset
// - Characters: start, eight bits LSB first, stop
// - Reply may start right after stop bit
// - Host drives stop bit high at most half bit
// - Host drives pin open-drain where feasible
// - Debugger silent until first host character
// - Host first character is 80H
// - Measure low period of first character
// ----------------------------------------------------------------------------
package dbg_link_pkg;
    localparam int          BYTE_W        = 8;
    localparam int          CNT_W         = 16;
    localparam int          KEY_W         = 32;
    localparam int          FIFO_DEPTH    = 8;
    localparam int          STRAP_HOLD_CYC = 5000;
    localparam int          KEY_BIT_CYC   = 16;
    localparam int          HOST_BIT_CYC  = 32;
    localparam int          AB_SHIFT      = 3;
    localparam logic [15:0] KEY_BIT_M1    = 16'h000F;
    localparam logic [15:0] KEY_FIRST_M1  = 16'h0017;
    localparam logic [15:0] MIN_BIT_CYC   = 16'h0004;
    localparam logic [15:0] CNT_ONE       = 16'h0001;
    localparam logic [15:0] CNT_MAX       = 16'hFFFF;
    localparam logic [3:0]  IDX_STOP      = 4'h9;
    localparam logic [5:0]  KEY_LAST      = 6'h1F;
    localparam logic [5:0]  KEY_SEND_LAST = 6'h20;
    localparam logic [7:0]  AUTOBAUD_CHAR = 8'h80;
    // Unlock key value is arbitrary
    localparam logic [31:0] UNLOCK_KEY    = 32'h5A3C_96E1;

    typedef enum logic [1:0] {
        AB_WAIT_HIGH = 2'b00,
        AB_WAIT_LOW  = 2'b01,
        AB_MEASURE   = 2'b11,
        LINK_RUN     = 2'b10
    } dev_state_e;

    typedef enum logic [2:0] {
        H_KEY      = 3'b000,
        H_HOLD     = 3'b001,
        H_AUTOBAUD = 3'b011,
        H_IDLE     = 3'b010,
        H_TX       = 3'b110,
        H_RX       = 3'b111
    } host_state_e;
endpackage

// ---- inc/dbg_link_if.sv ----
// Interface joining the device and host ends of the debug pin
`timescale 1ns/1ps
`default_nettype none
interface dbg_link_if;
    logic pin;
    logic dev_out;
    logic dev_oe_b;
    logic host_out;
    logic host_oe_b;
    logic rst_pin;
    logic host_rst_out;
    logic host_rst_oe_b;

    // Pulled-up wired line: any enabled driver at zero pulls it low
    assign pin     = (dev_oe_b | dev_out) & (host_oe_b | host_out);
    assign rst_pin = host_rst_oe_b | host_rst_out;

    modport dev (input pin, input rst_pin, output dev_out, output dev_oe_b);
    modport host (input pin, output host_out, output host_oe_b,
                  output host_rst_out, output host_rst_oe_b);
endinterface
`default_nettype wire

// ---- hw/dbg_port_host.sv ----
// Host end of the debug link: key, strap, auto-baud and characters
`timescale 1ns/1ps
`default_nettype none
module dbg_port_host #(
    parameter int          BIT_CYC  = dbg_link_pkg::HOST_BIT_CYC,
    parameter int          HOLD_CYC = dbg_link_pkg::STRAP_HOLD_CYC,
    parameter logic [31:0] KEY      = dbg_link_pkg::UNLOCK_KEY
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_b,
    // Link pins
    dbg_link_if.host        link,
    // Start-up options
    input  wire logic       key_req,
    input  wire logic       strap_req,
    // Character stream
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_valid,
    output logic            tx_ready,
    output logic [7:0]      rx_data,
    output logic            rx_valid
);
    localparam logic [15:0] BIT_M1  = 16'(BIT_CYC - 1);
    localparam logic [15:0] HALF_M1 = 16'(BIT_CYC / 2 - 1);
    localparam logic [15:0] HOLD_T  = 16'(HOLD_CYC);
    localparam logic [15:0] HOLD_M1 = 16'(HOLD_CYC
                                          + dbg_link_pkg::KEY_BIT_CYC - 1);

    typedef struct packed {
        dbg_link_pkg::host_state_e st;
        logic          p1;
        logic          p2;
        logic          pd;
        logic [15:0]   tmr;
        logic [5:0]    idx;
        logic [32:0]   sr;
        logic          drv_low;
        logic          rst_low;
        logic [7:0]    rx_sr;
        logic [7:0]    rx_data;
        logic          rx_valid;
    } host_s;
    host_s q;
    host_s d;

    assign tx_ready = (q.st == dbg_link_pkg::H_IDLE);

    // Next-state logic
    always_comb
    begin
        d = q;
        d.p1 = link.pin;
        d.p2 = q.p1;
        d.pd = q.p2;
        d.rx_valid = 1'b0;
        case (q.st)
            // Leading zero then key MSB first, device held in reset
            dbg_link_pkg::H_KEY:
                if (!key_req || (q.rst_low && q.tmr == '0
                                 && q.idx == dbg_link_pkg::KEY_SEND_LAST))
                begin
                    d.rst_low = strap_req;
                    d.drv_low = strap_req;
                    d.tmr = HOLD_M1;
                    d.st = strap_req ? dbg_link_pkg::H_HOLD
                                     : dbg_link_pkg::H_AUTOBAUD;
                end
                else if (!q.rst_low)
                begin
                    d.rst_low = 1'b1;
                    d.sr = {1'b0, KEY};
                    d.drv_low = 1'b1;
                    d.idx = '0;
                    d.tmr = dbg_link_pkg::KEY_BIT_M1;
                end
                else if (q.tmr == '0)
                begin
                    d.sr = {q.sr[31:0], 1'b1};
                    d.drv_low = !q.sr[31];
                    d.idx = q.idx + 6'h01;
                    d.tmr = dbg_link_pkg::KEY_BIT_M1;
                end
                else
                    d.tmr = q.tmr - dbg_link_pkg::CNT_ONE;
            // Pin low across reset release, then a long low tail
            dbg_link_pkg::H_HOLD:
            begin
                d.rst_low = (q.tmr > HOLD_T);
                if (q.tmr == '0)
                begin
                    d.drv_low = 1'b0;
                    d.st = dbg_link_pkg::H_AUTOBAUD;
                end
                else
                    d.tmr = q.tmr - dbg_link_pkg::CNT_ONE;
            end
            dbg_link_pkg::H_AUTOBAUD:
            begin
                d.sr = {23'h00_0000, 1'b1, dbg_link_pkg::AUTOBAUD_CHAR, 1'b0};
                d.idx = '0;
                d.tmr = BIT_M1;
                d.drv_low = 1'b1;
                d.st = dbg_link_pkg::H_TX;
            end
            dbg_link_pkg::H_IDLE:
                if (tx_valid)
                begin
                    d.sr = {23'h00_0000, 1'b1, tx_data, 1'b0};
                    d.idx = '0;
                    d.tmr = BIT_M1;
                    d.drv_low = 1'b1;
                    d.st = dbg_link_pkg::H_TX;
                end
                else if (q.pd && !q.p2)
                begin
                    d.idx = '0;
                    d.tmr = HALF_M1;
                    d.st = dbg_link_pkg::H_RX;
                end
            // Stop bit is released, never driven, and cut to half a bit
            dbg_link_pkg::H_TX:
                if (q.tmr == '0)
                begin
                    if (q.idx[3:0] == dbg_link_pkg::IDX_STOP)
                        d.st = dbg_link_pkg::H_IDLE;
                    else
                    begin
                        d.sr = {1'b0, q.sr[32:1]};
                        d.drv_low = !q.sr[1];
                        d.idx = q.idx + 6'h01;
                        d.tmr = (q.idx[3:0] == dbg_link_pkg::IDX_STOP - 4'h1)
                                ? HALF_M1 : BIT_M1;
                    end
                end
                else
                    d.tmr = q.tmr - dbg_link_pkg::CNT_ONE;
            dbg_link_pkg::H_RX:
                if (q.tmr == '0)
                begin
                    d.tmr = BIT_M1;
                    d.idx = q.idx + 6'h01;
                    if (q.idx == '0)
                        d.st = q.p2 ? dbg_link_pkg::H_IDLE : dbg_link_pkg::H_RX;
                    else if (q.idx[3:0] == dbg_link_pkg::IDX_STOP)
                    begin
                        d.st = dbg_link_pkg::H_IDLE;
                        d.rx_valid = q.p2;
                        if (q.p2)
                            d.rx_data = q.rx_sr;
                    end
                    else
                        d.rx_sr = {q.p2, q.rx_sr[7:1]};
                end
                else
                    d.tmr = q.tmr - dbg_link_pkg::CNT_ONE;
            default:
                d.st = dbg_link_pkg::H_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            q <= '0;
            q.p1 <= 1'b1;
            q.p2 <= 1'b1;
            q.pd <= 1'b1;
        end
        else
            q <= d;
    end

    // Open-drain drive of both pins, output data fixed low
    assign link.host_out      = 1'b0;
    assign link.host_oe_b     = !q.drv_low;
    assign link.host_rst_out  = 1'b0;
    assign link.host_rst_oe_b = !q.rst_low;
    assign rx_data            = q.rx_data;
    assign rx_valid           = q.rx_valid;
endmodule
`default_nettype wire

// ---- test/dbg_link_asserts.sv ----
// Checker on the wires between the two ends of the debug link
`timescale 1ns/1ps
`default_nettype none
module dbg_link_asserts (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Link wires
    input wire logic pin,
    input wire logic dev_out,
    input wire logic dev_oe_b,
    input wire logic host_out,
    input wire logic host_oe_b,
    input wire logic rst_pin
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // Set once the host has pulled the line; the device must wait for it
    logic heard_q;
    logic heard_d;
    always_comb heard_d = heard_q | (!pin & dev_oe_b);
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            heard_q <= 1'b0;
        else
            heard_q <= heard_d;
    end
    property p_quiet; !heard_q |-> dev_oe_b; endproperty
    a_quiet: assert property (p_quiet)
        else $error("device talked before host");
    property p_odrain; !host_oe_b |-> !host_out; endproperty
    a_odrain: assert property (p_odrain)
        else $error("host drove line high");
    property p_nocoll; !dev_oe_b |-> host_oe_b; endproperty
    a_nocoll: assert property (p_nocoll)
        else $error("both ends drive line");
    property p_start; $fell(dev_oe_b) |-> !dev_out ##1 !pin [*3]; endproperty
    a_start: assert property (p_start)
        else $error("bad device start bit");
    property p_stop; $rose(dev_oe_b) |-> $past(dev_out); endproperty
    a_stop: assert property (p_stop)
        else $error("device stop bit not high");
    property p_bit;
        !dev_oe_b && $changed(dev_out) |=> (dev_oe_b || $stable(dev_out)) [*3];
    endproperty
    a_bit: assert property (p_bit)
        else $error("device bit too short");
    property p_hchar; $fell(host_oe_b) |-> !pin [*8]; endproperty
    a_hchar: assert property (p_hchar)
        else $error("host low too short");
    property p_rst; !rst_pin [*3] |-> dev_oe_b; endproperty
    a_rst: assert property (p_rst)
        else $error("device drives in reset");
    c_dev: cover property ($fell(dev_oe_b));
    c_host: cover property ($fell(host_oe_b));
    c_rst: cover property ($fell(rst_pin));
endmodule
`default_nettype wire

// ---- test/testbench.sv ----
// Self-checking bench for both ends of the debug link
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin failures++; \
    $display("Error %0t: value mismatch", $time); end end
module testbench;
    logic clk, rst_b, breakpoint_instruction, stop, halted, clr, wdt_rst, d_txv, h_txv;
    logic exq, key, unl;
    logic dbg, fetch, hexit, refr, prun, sreq, d_txr, d_rxv, h_txr, h_rxv;
    logic [7:0] d_txd, h_txd, d_rxd, h_rxd;
    logic [31:0] seed;
    int failures, n_checks;
    dbg_link_if dbg_link_if_inst ();
    dbg_port_dev dbg_port_dev_inst (.clk(clk), .rst_b(rst_b),
        .link(dbg_link_if_inst), .brownout_rst(1'b0), .wdt_rst(wdt_rst),
        .brk_exec(breakpoint_instruction), .stop_mode(stop), .core_halted(halted),
        .wdt_enabled(1'b1), .exec_req(exq), .debug_mode_clr(clr),
        .debug_active_bit(dbg), .fetch_en(fetch), .halt_exit(hexit),
        .wdt_refresh(refr), .periph_run(prun), .sys_reset_req(sreq),
        .unlocked(unl), .tx_data(d_txd), .tx_valid(d_txv), .tx_ready(d_txr),
        .rx_data(d_rxd), .rx_valid(d_rxv));
    // Short strap hold keeps the run brief
    dbg_port_host #(.HOLD_CYC(40)) dbg_port_host_inst (.clk(clk),
        .rst_b(rst_b), .link(dbg_link_if_inst), .key_req(key),
        .strap_req(1'b1), .tx_data(h_txd), .tx_valid(h_txv),
        .tx_ready(h_txr), .rx_data(h_rxd), .rx_valid(h_rxv));
    dbg_link_asserts dbg_link_asserts_inst (.clk(clk), .rst_b(rst_b),
        .pin(dbg_link_if_inst.pin), .dev_out(dbg_link_if_inst.dev_out),
        .dev_oe_b(dbg_link_if_inst.dev_oe_b),
        .host_out(dbg_link_if_inst.host_out),
        .host_oe_b(dbg_link_if_inst.host_oe_b),
        .rst_pin(dbg_link_if_inst.rst_pin));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction
    task automatic final_report();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Bounded wait at falling edges, so pulses are seen settled
    task automatic wt(input int s);
        for (int i = 0; i < 6000; i++)
        begin
            @(negedge clk);
            if ((s == 0 && d_rxv === 1'b1) || (s == 1 && h_rxv === 1'b1) ||
                (s == 2 && dbg === 1'b1) || (s == 3 && h_txr === 1'b1) ||
                (s == 4 && dbg === 1'b0) || (s == 5 && sreq === 1'b1))
                return;
        end
        failures++;
        final_report();
    endtask
    task automatic hsend(input logic [7:0] b);
        wt(3);
        h_txd = b;
        h_txv = 1'b1;
        @(negedge clk);
        h_txv = 1'b0;
    endtask
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial
    begin
        logic [7:0] q[$];
        logic [7:0] b;
        {breakpoint_instruction, stop, halted, clr, wdt_rst, d_txv, h_txv, exq, key} = '0;
        {d_txd, h_txd, failures, n_checks} = '0;
        seed = 32'h0000_001E;
        rst_b = 1'b0;
        repeat (3) @(negedge clk);
        rst_b = 1'b1;
        wt(2);
        `CHK(fetch, 1'b0)
        `CHK(prun, 1'b1)
        `CHK(refr, 1'b1)
        `CHK(unl, 1'b0)
        // A directed instruction may fetch for one cycle in debug mode
        exq = 1'b1;
        @(negedge clk);
        exq = 1'b0;
        `CHK(fetch, 1'b1)
        // Corner bytes first, then random ones, host to device
        for (int k = 0; k < 5; k++)
        begin
            seed = xs(seed);
            b = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : seed[7:0];
            hsend(b);
            wt(0);
            `CHK(d_rxd, b)
        end
        // Overfill the FIFO; the slow line keeps it from draining
        for (int k = 0; k < 12; k++)
        begin
            seed = xs(seed);
            d_txv = d_txr;
            d_txd = seed[15:8];
            if (d_txr === 1'b1)
                q.push_back(seed[15:8]);
            @(negedge clk);
        end
        d_txv = 1'b0;
        `CHK(d_txr, 1'b0)
        while (q.size() > 0)
        begin
            wt(1);
            `CHK(h_rxd, q.pop_front())
        end
        clr = 1'b1;
        @(negedge clk);
        clr = 1'b0;
        `CHK(dbg, 1'b0)
        `CHK(fetch, 1'b1)
        halted = 1'b1;
        breakpoint_instruction = 1'b1;
        @(negedge clk);
        breakpoint_instruction = 1'b0;
        `CHK(dbg, 1'b1)
        `CHK(hexit, 1'b1)
        wdt_rst = 1'b1;
        wt(4);
        wdt_rst = 1'b0;
        repeat (3) @(negedge clk);
        breakpoint_instruction = 1'b1;
        @(negedge clk);
        breakpoint_instruction = 1'b0;
        wt(2);
        // Pin pulled low in stop mode must reset and leave debug
        stop = 1'b1;
        hsend(8'h00);
        wt(5);
        `CHK(prun, 1'b0)
        wt(4);
        // Mid-run reset with the unlock key sent under the reset pin
        stop = 1'b0;
        key = 1'b1;
        rst_b = 1'b0;
        repeat (3) @(negedge clk);
        rst_b = 1'b1;
        wt(2);
        `CHK(unl, 1'b1)
        hsend(8'h5A);
        wt(0);
        `CHK(d_rxd, 8'h5A)
        final_report();
    end
endmodule
`default_nettype wire
